/* logic/xts_exec.sv */
// Executor for xor-literal, xor-file and test-zero-skip instructions
`timescale 1ns/10ps
// Overview of operation
// - Literal xor into accumulator, one cycle
// - File xor updates only negative, zero flags
// - Destination bit picks accumulator or file
// - Bank bit 0 uses access bank
// - Bank bit 1 uses bank select register
// - Skip adds nop cycles, two for two-word
module xts_exec (
    input wire logic clock_in,                          // Core clock
    input wire logic reset_in,                          // Sync reset
    input wire logic [xts_pkg::INSTR_W-1:0] instr_in,   // Fetched word
    input wire logic instr_valid_in,                    // Word valid at Q1
    input wire logic instr_two_word_in,                 // Word is 2-word op
    input wire logic [xts_pkg::BANK_W-1:0] bank_select_register_in, // Bank
    input wire logic [xts_pkg::DATA_W-1:0] file_rdata_in, // Read data, Q2
    output logic [xts_pkg::ADDR_W-1:0] file_addr_out,   // File address
    output logic file_rd_out,                           // Read strobe
    output logic file_wr_out,                           // Write strobe
    output logic [xts_pkg::DATA_W-1:0] file_wdata_out,  // Write data
    output logic [xts_pkg::DATA_W-1:0] working_accumulator_out, // Acc
    output logic flag_n_out,                            // Negative flag
    output logic flag_z_out,                            // Zero flag
    output logic skip_pending_out,                      // Next slot is nop
    output logic cycle_done_out                         // Q4 end pulse
);
    import xts_pkg::*;

    xts_phase_t phase;
    xts_op_t op_r, op_nxt;
    logic [INSTR_W-1:0] instr_r, instr_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic rd_r, rd_nxt, wr_r, wr_nxt, done_r, done_nxt;
    logic [DATA_W-1:0] wdata_r, wdata_nxt, acc_r, acc_nxt;
    logic [DATA_W-1:0] opnd_r, opnd_nxt, result_r, result_nxt;
    logic n_r, n_nxt, z_r, z_nxt;
    logic skip_pending_r, skip_pending_nxt;
    logic skip_second_r, skip_second_nxt;

    xts_qphase u_qphase (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .phase_out(phase)
    );

    always_comb
    begin
        op_nxt = op_r;
        instr_nxt = instr_r;
        addr_nxt = addr_r;
        rd_nxt = 1'b0;
        wr_nxt = 1'b0;
        done_nxt = 1'b0;
        wdata_nxt = wdata_r;
        acc_nxt = acc_r;
        opnd_nxt = opnd_r;
        result_nxt = result_r;
        n_nxt = n_r;
        z_nxt = z_r;
        skip_pending_nxt = skip_pending_r;
        skip_second_nxt = skip_second_r;
        case (phase)
            XTS_Q1:
            begin
                instr_nxt = instr_in;
                op_nxt = XTS_OP_NOP;
                if (!instr_valid_in)
                    op_nxt = XTS_OP_NOP;
                else if (skip_pending_r)
                begin
                    // Skipped word; a two-word op costs one more slot
                    skip_pending_nxt = 1'b0;
                    skip_second_nxt = instr_two_word_in;
                end
                else if (skip_second_r)
                    skip_second_nxt = 1'b0;
                else if (instr_in[15:8] == OPC_XOR_LIT)
                    op_nxt = XTS_OP_XOR_LIT;
                else if (instr_in[15:10] == OPC_XOR_FILE)
                    op_nxt = XTS_OP_XOR_FILE;
                else if (instr_in[15:9] == OPC_TEST_ZERO)
                    op_nxt = XTS_OP_TEST_ZERO;
                if (instr_in[BANK_BIT])
                    addr_nxt = {bank_select_register_in,
                                instr_in[7:0]};
                else if (instr_in[7:0] < ACCESS_SPLIT)
                    addr_nxt = {ACCESS_LOW_BANK, instr_in[7:0]};
                else
                    addr_nxt = {ACCESS_HIGH_BANK, instr_in[7:0]};
                rd_nxt = (op_nxt == XTS_OP_XOR_FILE) ||
                         (op_nxt == XTS_OP_TEST_ZERO);
            end
            XTS_Q2:
            begin
                opnd_nxt = (op_r == XTS_OP_XOR_LIT) ? instr_r[7:0]
                                                   : file_rdata_in;
            end
            XTS_Q3:
            begin
                result_nxt = acc_r ^ opnd_r;
            end
            XTS_Q4:
            begin
                done_nxt = 1'b1;
                case (op_r)
                    XTS_OP_XOR_LIT:
                    begin
                        acc_nxt = result_r;
                        n_nxt = result_r[DATA_W-1];
                        z_nxt = (result_r == ZERO_BYTE);
                    end
                    XTS_OP_XOR_FILE:
                    begin
                        // Only N and Z move; other status is not ours
                        n_nxt = result_r[DATA_W-1];
                        z_nxt = (result_r == ZERO_BYTE);
                        if (instr_r[DEST_BIT])
                        begin
                            wr_nxt = 1'b1;
                            wdata_nxt = result_r;
                        end
                        else
                            acc_nxt = result_r;
                    end
                    XTS_OP_TEST_ZERO:
                        skip_pending_nxt = (opnd_r == ZERO_BYTE);
                    default:
                        done_nxt = 1'b1;
                endcase
            end
            default:
                done_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            op_r <= XTS_OP_NOP;
            instr_r <= '0;
            addr_r <= '0;
            rd_r <= 1'b0;
            wr_r <= 1'b0;
            done_r <= 1'b0;
            wdata_r <= '0;
            acc_r <= ACC_RESET;
            opnd_r <= '0;
            result_r <= '0;
            n_r <= 1'b0;
            z_r <= 1'b0;
            skip_pending_r <= 1'b0;
            skip_second_r <= 1'b0;
        end
        else
        begin
            op_r <= op_nxt;
            instr_r <= instr_nxt;
            addr_r <= addr_nxt;
            rd_r <= rd_nxt;
            wr_r <= wr_nxt;
            done_r <= done_nxt;
            wdata_r <= wdata_nxt;
            acc_r <= acc_nxt;
            opnd_r <= opnd_nxt;
            result_r <= result_nxt;
            n_r <= n_nxt;
            z_r <= z_nxt;
            skip_pending_r <= skip_pending_nxt;
            skip_second_r <= skip_second_nxt;
        end
    end

    assign file_addr_out = addr_r;
    assign file_rd_out = rd_r;
    assign file_wr_out = wr_r;
    assign file_wdata_out = wdata_r;
    assign working_accumulator_out = acc_r;
    assign flag_n_out = n_r;
    assign flag_z_out = z_r;
    assign skip_pending_out = skip_pending_r;
    assign cycle_done_out = done_r;

    // Helper: consecutive skipped slots, only for checking
    logic [1:0] nop_run_r;
    always_ff @(posedge clock_in)
    begin
        if (reset_in)
            nop_run_r <= '0;
        else if (phase == XTS_Q1 && instr_valid_in)
            nop_run_r <= (skip_pending_r || skip_second_r)
                         ? nop_run_r + 2'h1 : 2'h0;
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);

    xor_lit_acc_a: assert property (
        phase == XTS_Q2 && op_r == XTS_OP_XOR_LIT
        |=> ##2 working_accumulator_out ==
            ($past(working_accumulator_out, 3) ^ $past(instr_r[7:0], 3)))
        else $error("literal xor result wrong");

    xor_file_flags_a: assert property (
        phase == XTS_Q4 && op_r == XTS_OP_XOR_FILE
        |=> flag_z_out == ($past(result_r) == ZERO_BYTE) &&
            flag_n_out == $past(result_r[DATA_W-1]))
        else $error("file xor flags wrong");

    xor_file_dest_a: assert property (
        phase == XTS_Q4 && op_r == XTS_OP_XOR_FILE
        |=> (file_wr_out == $past(instr_r[DEST_BIT])) &&
            ($past(instr_r[DEST_BIT]) ? $stable(working_accumulator_out)
                                      : working_accumulator_out ==
                                        $past(result_r)))
        else $error("file xor destination wrong");

    access_bank_a: assert property (
        phase == XTS_Q1 && !instr_in[BANK_BIT]
        |=> file_addr_out[ADDR_W-1:DATA_W] ==
            (($past(instr_in[7:0]) < ACCESS_SPLIT) ? ACCESS_LOW_BANK
                                                    : ACCESS_HIGH_BANK))
        else $error("access bank address wrong");

    banked_addr_a: assert property (
        phase == XTS_Q1 && instr_in[BANK_BIT]
        |=> file_addr_out == {$past(bank_select_register_in),
                              $past(instr_in[7:0])})
        else $error("banked address wrong");

    skip_len_a: assert property (
        nop_run_r <= MAX_NOP_SLOTS)
        else $error("too many skipped slots");

    test_skip_a: assert property (
        phase == XTS_Q4 && op_r == XTS_OP_TEST_ZERO
        |=> skip_pending_out == ($past(opnd_r) == ZERO_BYTE) &&
            $stable(flag_z_out) && $stable(flag_n_out) && !file_wr_out)
        else $error("test zero skip wrong");

    skip_nop_a: assert property (
        phase == XTS_Q1 && instr_valid_in && skip_pending_r
        |=> op_r == XTS_OP_NOP ##3 !file_wr_out &&
            $stable(working_accumulator_out))
        else $error("skipped slot executed");

    lit_c: cover property (phase == XTS_Q4 && op_r == XTS_OP_XOR_LIT);
    file_wr_c: cover property (file_wr_out);
    skip_two_c: cover property (skip_second_r && phase == XTS_Q1);
    banked_c: cover property (phase == XTS_Q4 &&
                              op_r == XTS_OP_XOR_FILE && instr_r[BANK_BIT]);
endmodule

/* logic/xts_pkg.sv */
// Shared constants and types for the xor and test-skip executor
package xts_pkg;
    localparam int DATA_W = 8;
    localparam int BANK_W = 4;
    localparam int ADDR_W = DATA_W + BANK_W;
    localparam int INSTR_W = 16;

    // Opcode fields, matched against the top bits of the word
    localparam logic [7:0] OPC_XOR_LIT = 8'h0a;
    localparam logic [5:0] OPC_XOR_FILE = 6'h06;
    localparam logic [6:0] OPC_TEST_ZERO = 7'h33;
    localparam int DEST_BIT = 9;
    localparam int BANK_BIT = 8;

    // Access bank: low half maps to bank 0, high half to the top bank
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;

    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [1:0] MAX_NOP_SLOTS = 2'h2;

    typedef enum logic [3:0] {
        XTS_Q1 = 4'h1,
        XTS_Q2 = 4'h2,
        XTS_Q3 = 4'h4,
        XTS_Q4 = 4'h8
    } xts_phase_t;

    typedef enum logic [3:0] {
        XTS_OP_NOP = 4'h1,
        XTS_OP_XOR_LIT = 4'h2,
        XTS_OP_XOR_FILE = 4'h4,
        XTS_OP_TEST_ZERO = 4'h8
    } xts_op_t;
endpackage

/* logic/xts_qphase.sv */
// Four-phase sequencer that splits each instruction cycle
`timescale 1ns/10ps
module xts_qphase (
    input wire logic clock_in,               // Core clock
    input wire logic reset_in,               // Synchronous reset
    output xts_pkg::xts_phase_t phase_out    // Current one-hot phase
);
    import xts_pkg::*;

    xts_phase_t phase_r;
    xts_phase_t phase_nxt;

    always_comb
    begin
        case (phase_r)
            XTS_Q1: phase_nxt = XTS_Q2;
            XTS_Q2: phase_nxt = XTS_Q3;
            XTS_Q3: phase_nxt = XTS_Q4;
            XTS_Q4: phase_nxt = XTS_Q1;
            default: phase_nxt = XTS_Q1;
        endcase
    end

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
            phase_r <= XTS_Q1;
        else
            phase_r <= phase_nxt;
    end

    assign phase_out = phase_r;
endmodule

/* verif/testbench.sv */
// Self-checking bench for the xor and test-zero-skip executor
`timescale 1ns/10ps
module testbench;
    import xts_pkg::*;

    logic clock_in;
    logic reset_in;
    logic [15:0] instr_in;
    logic instr_valid_in;
    logic instr_two_word_in;
    logic [3:0] bank_sel;
    logic [7:0] file_rdata_in;
    logic [11:0] file_addr_out;
    logic file_rd_out;
    logic file_wr_out;
    logic [7:0] file_wdata_out;
    logic [7:0] acc_out;
    logic flag_n_out;
    logic flag_z_out;
    logic skip_pending_out;
    logic cycle_done_out;
    int n_mismatch;
    int compares;

    xts_exec xts_exec_inst (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .instr_in(instr_in),
        .instr_valid_in(instr_valid_in),
        .instr_two_word_in(instr_two_word_in),
        .bank_select_register_in(bank_sel),
        .file_rdata_in(file_rdata_in),
        .file_addr_out(file_addr_out),
        .file_rd_out(file_rd_out),
        .file_wr_out(file_wr_out),
        .file_wdata_out(file_wdata_out),
        .working_accumulator_out(acc_out),
        .flag_n_out(flag_n_out),
        .flag_z_out(flag_z_out),
        .skip_pending_out(skip_pending_out),
        .cycle_done_out(cycle_done_out)
    );

    initial
    begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end

    task automatic wrap_up();
        if (n_mismatch == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [15:0] xlit(input logic [7:0] k);
        return {OPC_XOR_LIT, k};
    endfunction

    function automatic logic [15:0] xfile(input logic d, input logic a,
                                          input logic [7:0] f);
        return {OPC_XOR_FILE, d, a, f};
    endfunction

    function automatic logic [15:0] tzero(input logic a, input logic [7:0] f);
        return {OPC_TEST_ZERO, a, f};
    endfunction

    // One instruction cycle; called and returning at a falling edge
    task automatic slot(input logic [15:0] w, input logic tw,
                        input logic [7:0] rd, input logic [11:0] ea,
                        input logic ca);
        instr_in = w;
        instr_valid_in = 1'b1;
        instr_two_word_in = tw;
        file_rdata_in = rd;
        @(posedge clock_in);
        @(negedge clock_in);
        if (ca)
        begin
            chk(16'(file_addr_out), 16'(ea));
        end
        // Read strobe only for file operands; pulses from Q4 are gone
        chk(16'(file_rd_out), 16'(ca));
        chk(16'(cycle_done_out), 16'h0000);
        chk(16'(file_wr_out), 16'h0000);
        instr_valid_in = 1'b0;
        repeat (3)
        begin
            @(posedge clock_in);
            @(negedge clock_in);
        end
        chk(16'(cycle_done_out), 16'h0001);
    endtask

    // Results seen in the cycle after the Q4 edge
    task automatic post(input logic [7:0] acc, input logic n,
                        input logic z, input logic wr);
        chk(16'(acc_out), 16'(acc));
        chk(16'({flag_n_out, flag_z_out}), 16'({n, z}));
        chk(16'(file_wr_out), 16'(wr));
    endtask

    initial
    begin
        repeat (2000) @(posedge clock_in);
        n_mismatch++;
        wrap_up();
    end

    initial
    begin
        n_mismatch = 0;
        compares = 0;
        reset_in = 1'b1;
        instr_in = 16'h0000;
        instr_valid_in = 1'b0;
        instr_two_word_in = 1'b0;
        bank_sel = 4'h0;
        file_rdata_in = 8'h00;
        repeat (10) @(negedge clock_in);
        post(8'h00, 1'b0, 1'b0, 1'b0);
        // First edge after release is a Q1 edge
        reset_in = 1'b0;
        slot(xlit(8'hb5), 1'b0, 8'h00, 12'h000, 1'b0);
        post(8'hb5, 1'b1, 1'b0, 1'b0);
        slot(xlit(8'haf), 1'b0, 8'h00, 12'h000, 1'b0);
        post(8'h1a, 1'b0, 1'b0, 1'b0);
        slot(xlit(8'h1a), 1'b0, 8'h00, 12'h000, 1'b0);
        post(8'h00, 1'b0, 1'b1, 1'b0);
        slot(xlit(8'hb5), 1'b0, 8'h00, 12'h000, 1'b0);
        slot(xfile(1'b1, 1'b0, 8'h23), 1'b0, 8'haf, 12'h023, 1'b1);
        post(8'hb5, 1'b0, 1'b0, 1'b1);
        chk(16'(file_wdata_out), 16'h001a);
        // Bank select must be ignored for access-bank operands
        bank_sel = 4'h5;
        slot(xfile(1'b0, 1'b0, 8'h90), 1'b0, 8'h3c, 12'hf90, 1'b1);
        post(8'h89, 1'b1, 1'b0, 1'b0);
        slot(xfile(1'b1, 1'b1, 8'h90), 1'b0, 8'h89, 12'h590, 1'b1);
        post(8'h89, 1'b0, 1'b1, 1'b1);
        chk(16'(file_wdata_out), 16'h0000);
        slot(tzero(1'b1, 8'h12), 1'b0, 8'h01, 12'h512, 1'b1);
        post(8'h89, 1'b0, 1'b1, 1'b0);
        chk(16'(skip_pending_out), 16'h0000);
        slot(tzero(1'b0, 8'h12), 1'b0, 8'h00, 12'h012, 1'b1);
        post(8'h89, 1'b0, 1'b1, 1'b0);
        chk(16'(skip_pending_out), 16'h0001);
        slot(xlit(8'hff), 1'b0, 8'h00, 12'h000, 1'b0);
        post(8'h89, 1'b0, 1'b1, 1'b0);
        chk(16'(skip_pending_out), 16'h0000);
        // Two-word follower: both of its slots become no-ops
        slot(tzero(1'b0, 8'h40), 1'b0, 8'h00, 12'h040, 1'b1);
        slot(xlit(8'hff), 1'b1, 8'h00, 12'h000, 1'b0);
        post(8'h89, 1'b0, 1'b1, 1'b0);
        slot(xlit(8'hff), 1'b0, 8'h00, 12'h000, 1'b0);
        post(8'h89, 1'b0, 1'b1, 1'b0);
        slot(xlit(8'h0f), 1'b0, 8'h00, 12'h000, 1'b0);
        post(8'h86, 1'b1, 1'b0, 1'b0);
        wrap_up();
    end
endmodule
